// ==== intc_pkg.sv ====
// constants for the flag clear and micro dma start vector block
package intc_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_START_VEC_CH0   = 8'h80;
  localparam logic [7:0] IDX_START_VEC_CH1   = 8'h81;
  localparam logic [7:0] IDX_START_VEC_CH2   = 8'h82;
  localparam logic [7:0] IDX_START_VEC_CH3   = 8'h83;
  localparam logic [7:0] IDX_FLAG_CLEAR      = 8'h88;
  localparam logic [7:0] IDX_SOFT_REQUEST    = 8'h89;
  localparam logic [7:0] IDX_BURST_SELECT    = 8'h8a;
  localparam logic [7:0] IDX_EXT_MODE        = 8'h8c;
  localparam logic [7:0] IDX_IRQ_STATUS      = 8'ha8;
  localparam logic [7:0] IDX_IRQ_MASK        = 8'ha9;

  // ==========================================================
  // widths and field positions
  localparam int NUM_CH       = 4;
  localparam int NUM_VEC      = 64;
  localparam int VEC_W        = 6;
  localparam int STAT_W       = 5;
  localparam int STAT_DEFVEC  = 4;
  localparam int MODE_LEVEL   = 1;
  localparam int MODE_FALLING = 2;
  localparam int MODE_W       = 8;

  // ==========================================================
  // source codes and vector values
  localparam logic [5:0]  VEC_EXT_IRQ_ZERO = 6'h0a;
  localparam logic [5:0]  VEC_SERIAL_RX    = 6'h20;
  localparam logic [15:0] DEFAULT_VECTOR   = 16'h0008;

  // ==========================================================
  // reset values
  localparam logic [5:0] RST_START_VEC = 6'h00;
  localparam logic [3:0] RST_NIBBLE    = 4'h0;
  localparam logic [7:0] RST_MODE      = 8'h00;
  localparam logic [4:0] RST_STAT      = 5'h00;

endpackage

// ==== int_flag_clear_udma_start.sv ====
// interrupt flags, flag clear port and micro dma start vector assignment
`timescale 1ns/1ns
module int_flag_clear_udma_start (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [63:0] irq_src,
  input  wire logic        external_irq_zero,
  input  wire logic        serial_rx_buf_read,
  output logic             cpu_int_req,
  output logic      [5:0]  cpu_int_code,
  input  wire logic        cpu_accept,
  input  wire logic        cpu_vector_read,
  output logic      [15:0] cpu_vector,
  output logic             cpu_vector_valid,
  output logic      [3:0]  dma_req,
  output logic      [3:0]  dma_burst,
  input  wire logic [3:0]  dma_ack,
  input  wire logic [3:0]  dma_count_zero,
  output logic      [3:0]  dma_end_irq,
  output logic             irq
);

  // ==========================================================
  // state
  logic [5:0]  start_vec [4];
  logic [3:0]  soft_req;
  logic [3:0]  burst_sel;
  logic [3:0]  burst_run;
  logic [7:0]  ext_mode;
  logic [4:0]  irq_status;
  logic [4:0]  irq_mask;
  logic [63:0] flag;
  logic        ext_prev;
  logic [5:0]  acc_code;
  logic        acc_valid;

  // ==========================================================
  // bus decode
  logic        bus_req;
  logic        wr_en;
  logic [7:0]  idx;
  logic [7:0]  wbyte;
  logic        clr_wr;
  logic        mode_wr;
  logic [31:0] next_rdata;

  assign bus_req = wb_cyc_i && wb_stb_i;
  // writes land only on the edge where the master sees ack
  assign wr_en   = bus_req && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign idx     = wb_adr_i[9:2];
  assign wbyte   = wb_dat_i[7:0];
  assign clr_wr  = wr_en && (idx == intc_pkg::IDX_FLAG_CLEAR);
  assign mode_wr = wr_en && (idx == intc_pkg::IDX_EXT_MODE);

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (idx == intc_pkg::IDX_START_VEC_CH0)
      next_rdata[5:0] = start_vec[0];
    else if (idx == intc_pkg::IDX_START_VEC_CH1)
      next_rdata[5:0] = start_vec[1];
    else if (idx == intc_pkg::IDX_START_VEC_CH2)
      next_rdata[5:0] = start_vec[2];
    else if (idx == intc_pkg::IDX_START_VEC_CH3)
      next_rdata[5:0] = start_vec[3];
    else if (idx == intc_pkg::IDX_SOFT_REQUEST)
      next_rdata[3:0] = soft_req;
    else if (idx == intc_pkg::IDX_BURST_SELECT)
      next_rdata[3:0] = burst_sel;
    else if (idx == intc_pkg::IDX_EXT_MODE)
      next_rdata[7:0] = ext_mode;
    else if (idx == intc_pkg::IDX_IRQ_STATUS)
      next_rdata[4:0] = irq_status;
    else if (idx == intc_pkg::IDX_IRQ_MASK)
      next_rdata[4:0] = irq_mask;
  end

  // one wait state; unmapped addresses still ack and read zero
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req && !wb_ack_o;
      if (bus_req && !wb_ack_o)
        wb_dat_o <= next_rdata;
    end
  end

  // ==========================================================
  // channel ownership
  logic [3:0] ch_owner;
  logic [3:0] ch_flag;
  logic [63:0] dma_owned;
  logic [63:0] ack_clr;
  logic [63:0] burst_clr;

  always_comb
  begin
    ch_owner  = 4'h0;
    ch_flag   = 4'h0;
    dma_owned = 64'h0;
    ack_clr   = 64'h0;
    burst_clr = 64'h0;
    for (int c = 0; c < intc_pkg::NUM_CH; c++)
    begin
      ch_owner[c] = (start_vec[c] != intc_pkg::RST_START_VEC);
      for (int l = 0; l < c; l++)
        if (start_vec[l] == start_vec[c])
          ch_owner[c] = 1'b0;
      ch_flag[c] = ch_owner[c] && flag[start_vec[c]];
      // owned sources are hidden from the cpu
      if (ch_owner[c])
        dma_owned[start_vec[c]] = 1'b1;
      if (ch_owner[c] && dma_ack[c])
        ack_clr[start_vec[c]] = 1'b1;
      if (ch_owner[c] && burst_run[c] && dma_count_zero[c])
        burst_clr[start_vec[c]] = 1'b1;
    end
  end

  // burst channels hold the request until counter zero
  assign dma_req   = ch_flag | soft_req | burst_run;
  assign dma_burst = burst_sel;

  // ==========================================================
  // start vectors
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int c = 0; c < intc_pkg::NUM_CH; c++)
        start_vec[c] <= intc_pkg::RST_START_VEC;
    end
    else
    begin
      for (int c = 0; c < intc_pkg::NUM_CH; c++)
      begin
        if (wr_en && idx == intc_pkg::IDX_START_VEC_CH0 + 8'(c))
          start_vec[c] <= wbyte[5:0];
        if (dma_count_zero[c])
          start_vec[c] <= intc_pkg::RST_START_VEC;
      end
    end
  end

  // ==========================================================
  // soft request, burst select, burst run
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      soft_req  <= intc_pkg::RST_NIBBLE;
      burst_sel <= intc_pkg::RST_NIBBLE;
      burst_run <= intc_pkg::RST_NIBBLE;
    end
    else
    begin
      // ones request, zeros leave pending bits alone
      if (wr_en && idx == intc_pkg::IDX_SOFT_REQUEST)
        soft_req <= (soft_req & ~dma_ack) | wbyte[3:0];
      else
        soft_req <= soft_req & ~dma_ack;
      if (wr_en && idx == intc_pkg::IDX_BURST_SELECT)
        burst_sel <= wbyte[3:0];
      // run latched on first unit, ended by counter zero
      burst_run <= (burst_run | (dma_ack & burst_sel)) & ~dma_count_zero;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      dma_end_irq <= intc_pkg::RST_NIBBLE;
    else
      dma_end_irq <= dma_count_zero;
  end

  // ==========================================================
  // external irq zero mode
  logic level_mode;
  logic to_level;
  logic ext_edge;
  logic ext_fall;

  assign level_mode = ext_mode[intc_pkg::MODE_LEVEL];
  assign to_level   = mode_wr && !level_mode && wbyte[intc_pkg::MODE_LEVEL];
  assign ext_fall   = ext_prev && !external_irq_zero;
  assign ext_edge   = ext_mode[intc_pkg::MODE_FALLING] ? ext_fall
                                                       : (!ext_prev &&
                                                          external_irq_zero);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ext_mode <= intc_pkg::RST_MODE;
      ext_prev <= 1'b0;
    end
    else
    begin
      if (mode_wr)
        ext_mode <= wbyte;
      ext_prev <= external_irq_zero;
    end
  end

  // ==========================================================
  // cpu vector path
  logic [63:0] cpu_pend;
  logic [63:0] vec_clr;
  logic        acc_live;

  always_comb
  begin
    cpu_pend = flag & ~dma_owned;
    // level mode request follows the pin, not the flop
    cpu_pend[intc_pkg::VEC_EXT_IRQ_ZERO] = level_mode ?
      (external_irq_zero && !dma_owned[intc_pkg::VEC_EXT_IRQ_ZERO]) :
      (flag[intc_pkg::VEC_EXT_IRQ_ZERO] &&
       !dma_owned[intc_pkg::VEC_EXT_IRQ_ZERO]);
    cpu_int_code = 6'h00;
    for (int v = intc_pkg::NUM_VEC - 1; v >= 0; v--)
      if (cpu_pend[v])
        cpu_int_code = 6'(v);
  end

  assign cpu_int_req = |cpu_pend;
  assign acc_live    = acc_valid && cpu_pend[acc_code];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      acc_code         <= 6'h00;
      acc_valid        <= 1'b0;
      cpu_vector       <= 16'h0000;
      cpu_vector_valid <= 1'b0;
    end
    else
    begin
      cpu_vector_valid <= cpu_vector_read;
      if (cpu_accept && cpu_int_req)
      begin
        acc_code  <= cpu_int_code;
        acc_valid <= 1'b1;
      end
      else if (cpu_vector_read)
        acc_valid <= 1'b0;
      if (cpu_vector_read)
      begin
        // flag gone before the read: default vector
        if (acc_live)
          cpu_vector <= {8'h00, acc_code, 2'b00};
        else
          cpu_vector <= intc_pkg::DEFAULT_VECTOR;
      end
    end
  end

  // ==========================================================
  // request flags, one per source code
  for (genvar v = 0; v < intc_pkg::NUM_VEC; v++)
  begin : g_flag
    logic set_v;
    logic clr_v;
    if (v == intc_pkg::VEC_EXT_IRQ_ZERO)
    begin : g_ext
      // level mode falling pin clears; edge mode uses the edge
      assign set_v = level_mode ? external_irq_zero : ext_edge;
      // leaving level mode keeps the flag
      assign clr_v = to_level || (level_mode && ext_fall) ||
                     (clr_wr && wbyte[5:0] == 6'(v)) ||
                     (cpu_vector_read && acc_live && acc_code == 6'(v)) ||
                     ack_clr[v] || burst_clr[v];
    end
    else if (v == intc_pkg::VEC_SERIAL_RX)
    begin : g_rx
      // clear port has no effect here
      assign set_v = irq_src[v];
      assign clr_v = serial_rx_buf_read;
    end
    else
    begin : g_std
      assign set_v = irq_src[v];
      assign clr_v = (clr_wr && wbyte[5:0] == 6'(v)) ||
                     (cpu_vector_read && acc_live && acc_code == 6'(v)) ||
                     ack_clr[v] || burst_clr[v];
    end
    always_ff @(posedge clk_sys)
    begin
      if (sys_rst)
        flag[v] <= 1'b0;
      else if (set_v)
        flag[v] <= 1'b1;
      else if (clr_v)
        flag[v] <= 1'b0;
    end
  end

  // ==========================================================
  // block interrupt: dma end events and default vector events
  logic [4:0] stat_set;

  assign stat_set = {cpu_vector_read && !acc_live, dma_count_zero};

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_status <= intc_pkg::RST_STAT;
      irq_mask   <= intc_pkg::RST_STAT;
    end
    else
    begin
      // set wins over a write-one clear in the same cycle
      if (wr_en && idx == intc_pkg::IDX_IRQ_STATUS)
        irq_status <= (irq_status & ~wbyte[4:0]) | stat_set;
      else
        irq_status <= irq_status | stat_set;
      if (wr_en && idx == intc_pkg::IDX_IRQ_MASK)
        irq_mask <= wbyte[4:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule // int_flag_clear_udma_start

// ==== int_flag_clear_udma_start_asserts.sv ====
// checker for the flag clear and micro dma start block
`timescale 1ns/1ns
module int_flag_clear_udma_start_asserts (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        cpu_vector_read,
  input wire logic [15:0] cpu_vector,
  input wire logic        cpu_vector_valid,
  input wire logic [63:0] irq_src,
  input wire logic        external_irq_zero,
  input wire logic [3:0]  dma_req,
  input wire logic [3:0]  dma_burst,
  input wire logic [3:0]  dma_ack,
  input wire logic [3:0]  dma_count_zero,
  input wire logic [3:0]  dma_end_irq
);
  // ==========
  // properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  bus_ack_a:
    assert property (bus_req |=> ack_once) else $error("bus ack wrong");
  rd_upper_a:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
  vec_valid_a:
    assert property (cpu_vector_read |=> cpu_vector_valid) else $error("vec");
  valid_cause_a:
    assert property (cpu_vector_valid |-> $past(cpu_vector_read))
      else $error("stray valid");
  vec_form_a:
    assert property (cpu_vector_valid |-> cpu_vector[15:8] == 8'h00
      && cpu_vector[1:0] == 2'b00) else $error("vector form");
  end_irq_a:
    assert property (|dma_count_zero |=> dma_end_irq == $past(dma_count_zero))
      else $error("end irq");
  // no new event on the channel, so its request must fall
  dma_drop_a:
    assert property (dma_ack[0] && !dma_burst[0] && irq_src == 64'h0
      && !external_irq_zero |=> !dma_req[0]) else $error("req held");
  burst_hold_a:
    assert property (dma_burst[2] && dma_ack[2] && !dma_count_zero[2]
      |=> dma_req[2]) else $error("burst stopped");
endmodule // int_flag_clear_udma_start_asserts
bind int_flag_clear_udma_start int_flag_clear_udma_start_asserts u_chk (.*);

// ==== cpu_dma_model.sv ====
// cpu core and micro dma engine model facing the block
`timescale 1ns/1ns
module cpu_dma_model #(
  parameter int COUNT = 2
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        irq_enable,
  input  wire logic        hold_read,
  input  wire logic        slow,
  input  wire logic        cpu_int_req,
  input  wire logic [15:0] cpu_vector,
  input  wire logic        cpu_vector_valid,
  input  wire logic [3:0]  dma_req,
  output logic             cpu_accept,
  output logic             cpu_vector_read,
  output logic      [15:0] last_vector,
  output logic      [3:0]  dma_ack,
  output logic      [3:0]  dma_count_zero
);
  logic       pend;
  logic       tick;
  logic [7:0] cnt [4];
  // ==========
  // cpu side
  // accept only while enabled
  always_ff @(posedge clk_sys)
  begin
    cpu_accept <= 1'b0;
    cpu_vector_read <= 1'b0;
    if (cpu_vector_valid)
      last_vector <= cpu_vector;
    if (sys_rst)
      pend <= 1'b0;
    else if (pend && !hold_read)
    begin
      cpu_vector_read <= 1'b1;
      pend <= 1'b0;
    end
    else if (!pend && !cpu_vector_read && irq_enable && cpu_int_req)
    begin
      cpu_accept <= 1'b1;
      pend <= 1'b1;
    end
  end
  // ==========
  // dma engine: slow mode stalls every other cycle
  // one unit taken per ack
  always_ff @(posedge clk_sys)
  begin
    tick <= sys_rst ? 1'b0 : !tick;
    dma_ack <= 4'h0;
    dma_count_zero <= 4'h0;
    for (int c = 0; c < 4; c++)
      if (sys_rst)
        cnt[c] <= 8'(COUNT);
      else if (dma_req[c] && !dma_ack[c] && (!slow || tick))
      begin
        dma_ack[c] <= 1'b1;
        dma_count_zero[c] <= (cnt[c] == 8'h01);
        cnt[c] <= (cnt[c] == 8'h01) ? 8'(COUNT) : cnt[c] - 8'h01;
      end
  end
endmodule // cpu_dma_model

// ==== testbench.sv ====
// self-checking bench for the flag clear and micro dma start block
`timescale 1ns/1ns
module testbench;
  logic        clk_sys = 1'b0, sys_rst = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0]  wb_adr_i = 10'h000;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, cpu_int_req, cpu_vector_valid, irq;
  logic [63:0] irq_src = 64'h0;
  logic        external_irq_zero = 1'b0, serial_rx_buf_read = 1'b0;
  logic        irq_enable = 1'b0, hold_read = 1'b0, slow = 1'b0;
  logic        cpu_accept, cpu_vector_read;
  logic [5:0]  cpu_int_code;
  logic [15:0] cpu_vector, last_vector;
  logic [3:0]  dma_req, dma_burst, dma_ack, dma_count_zero, dma_end_irq;
  int          num_errors = 0, comparisons = 0, cycles = 0, n;
  int          acks [4] = '{default: 0};
  // ==========
  // clock, parts, watchdog
  always #4 clk_sys = !clk_sys;
  int_flag_clear_udma_start u_dut (.*);
  cpu_dma_model #(.COUNT(2)) u_model (.*);
  always @(posedge clk_sys)
    for (int c = 0; c < 4; c++)
      acks[c] += int'(dma_ack[c] === 1'b1);
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      close_out;
    end
  end
  // ==========
  // shared tasks
  task automatic close_out;
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // classic cycle: hold until ack is sampled, then release
  // only the bench watchdog ends a wait for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_sel_i <= 4'hf;
    wb_adr_i <= {a, 2'b00};
    wb_dat_i <= {24'h0, d};
    do
      @(posedge clk_sys);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    wb_sel_i <= 4'h0;
  endtask
  task automatic src(input int c);
    @(posedge clk_sys) irq_src <= 64'h1 << c;
    @(posedge clk_sys) irq_src <= 64'h0;
  endtask
  task automatic pin(input logic v);
    @(posedge clk_sys) external_irq_zero <= v;
    step(3);
  endtask
  // ==========
  // scenarios
  task automatic t_regs;
    logic [7:0] r [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h88, 8'h89, 8'h8a};
    foreach (r[i])
    begin
      wb(0, r[i], 8'h00);
      chk(q, 32'h0);
    end
    wb(1, 8'h81, 8'hff);
    wb(0, 8'h81, 8'h00);
    chk(q, 32'h3f);
    wb(1, 8'h40, 8'hff);
    wb(0, 8'h40, 8'h00);
    chk(q, 32'h0);
    wb(1, 8'h81, 8'h00);
  endtask
  task automatic t_clear;
    src(5);
    step(2);
    chk({cpu_int_req, cpu_int_code}, 7'h45);
    wb(1, 8'h88, 8'h05);
    src(32);
    wb(1, 8'h88, 8'h20);
    step(1);
    chk({cpu_int_req, cpu_int_code}, 7'h60);
    @(posedge clk_sys) serial_rx_buf_read <= 1'b1;
    @(posedge clk_sys) serial_rx_buf_read <= 1'b0;
    step(1);
    chk(cpu_int_req, 1'b0);
  endtask
  task automatic t_ext0;
    pin(1);
    pin(0);
    chk({cpu_int_req, cpu_int_code}, 7'h4a);
    wb(1, 8'h8c, 8'h02);
    step(1);
    chk(cpu_int_req, 1'b0);
    // back in edge mode the flag stays clear, since entering level mode cleared it
    wb(1, 8'h8c, 8'h00);
    step(1);
    chk(cpu_int_req, 1'b0);
    wb(1, 8'h8c, 8'h02);
    pin(1);
    chk({cpu_int_req, cpu_int_code}, 7'h4a);
    pin(0);
    chk(cpu_int_req, 1'b0);
    wb(1, 8'h8c, 8'h00);
    step(1);
    chk(cpu_int_req, 1'b0);
    wb(1, 8'h8c, 8'h02);
    pin(1);
    wb(1, 8'h8c, 8'h00);
    pin(0);
    chk(cpu_int_req, 1'b1);
    wb(1, 8'h88, 8'h0a);
    step(1);
    chk(cpu_int_req, 1'b0);
    // falling edge mode: only a high to low change sets the flag
    wb(1, 8'h8c, 8'h04);
    pin(1);
    chk(cpu_int_req, 1'b0);
    pin(0);
    chk({cpu_int_req, cpu_int_code}, 7'h4a);
    wb(1, 8'h88, 8'h0a);
    step(1);
    chk(cpu_int_req, 1'b0);
  endtask
  task automatic t_dma;
    wb(1, 8'ha9, 8'h01);
    wb(1, 8'h80, 8'h07);
    wb(1, 8'h81, 8'h07);
    src(7);
    step(1);
    chk({cpu_int_req, dma_req}, 5'h01);
    step(3);
    src(7);
    step(6);
    chk(irq, 1'b1);
    wb(0, 8'h80, 8'h00);
    chk(q, 32'h0);
    wb(0, 8'ha8, 8'h00);
    chk(q, 32'h1);
    src(7);
    step(1);
    chk({cpu_int_req, dma_req}, 5'h02);
    wb(1, 8'ha9, 8'h00);
    step(1);
    chk(irq, 1'b0);
    wb(1, 8'ha8, 8'h01);
    wb(1, 8'ha9, 8'h01);
    step(1);
    chk(irq, 1'b0);
    wb(1, 8'h80, 8'h07);
    src(7);
    step(1);
    chk({cpu_int_req, dma_req}, 5'h01);
  endtask
  task automatic t_burst;
    @(posedge clk_sys) slow <= 1'b1;
    wb(1, 8'h8a, 8'h04);
    wb(1, 8'h89, 8'h04);
    for (n = 0; n < 60 && dma_end_irq[2] !== 1'b1; n++)
      @(posedge clk_sys);
    chk(acks[2], 2);
    chk(dma_burst, 4'h4);
    wb(0, 8'ha8, 8'h00);
    chk(q, 32'h4);
    wb(1, 8'ha8, 8'h04);
    wb(1, 8'h89, 8'h08);
    step(12);
    chk({acks[3][3:0], dma_req}, 8'h10);
  endtask
  task automatic t_vec;
    @(posedge clk_sys) {irq_enable, hold_read} <= 2'b11;
    src(3);
    for (n = 0; n < 20 && cpu_accept !== 1'b1; n++)
      @(posedge clk_sys);
    wb(1, 8'h88, 8'h03);
    {irq_enable, hold_read} <= 2'b00;
    step(4);
    chk(last_vector, 16'h0008);
    wb(0, 8'ha8, 8'h00);
    chk(q, 32'h10);
    irq_enable <= 1'b1;
    src(9);
    step(6);
    chk(last_vector, {8'h00, 6'h09, 2'b00});
    chk(cpu_int_req, 1'b0);
  endtask
  initial
  begin
    step(20);
    sys_rst <= 1'b0;
    t_regs;
    t_clear;
    t_ext0;
    t_dma;
    t_burst;
    t_vec;
    close_out;
  end
endmodule // testbench
